// file: shstr_tx.sv
// block fifo and sync header stream transmitter
// blocks wait in an eight-word fifo while the drain is held off by tx_en_in
// or by a sysref cycle; each drained block leaves one cycle later with a
// two-bit header that carries one bit of the stream word. the parity sent
// in a multiblock is that of the one before, so the first after reset is 0.
// a sysref mid-multiblock drops the partial parity and restarts at block 0.
`timescale 1ns/1ps
`include "shstr_map.svh"

module shstr_fifo #(
    parameter int W = 64,
    parameter int D = 8
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [W-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    // depth must be a power of two; pointers carry one wrap bit
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [W-1:0] mem_d [D];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic full, empty, push, pop;

    // honest flags from pointer compare
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);

    // handshake on both sides, combinational so a word moves every cycle
    assign push = wr_valid_in && !full;
    assign pop = rd_valid_out && rd_ready_in;
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_q[rd_q[AW-1:0]];

    // pointer next values
    always_comb begin
        wr_d = wr_q + {{AW{1'b0}}, push};
        rd_d = rd_q + {{AW{1'b0}}, pop};
    end

    // pointers only; full and empty follow from them
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // storage next value; only the slot under the write pointer changes
    always_comb begin
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q[AW-1:0]] = wr_data_in;
        end
    end

    // storage needs no reset, only written words are read
    always_ff @(posedge sys_clk_in) begin
        mem_q <= mem_d;
    end
endmodule

module shstr_tx
    import shstr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic sysref_in,
    input wire logic tx_en_in,
    input wire logic [63:0] blk_in,
    input wire logic blk_valid_in,
    output logic blk_ready_out,
    output logic lemc_out,
    shstr_if.tx link
);
    // fifo side, stream word, framing state and link stage
    logic [63:0] f_data;
    logic f_valid, pop, bit_c;
    logic [31:0] word_c;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] crc_q, crc_d, par_q, par_d;
    logic vld_q, vld_d, first_q, first_d;
    logic [1:0] sh_q, sh_d;
    logic [63:0] pay_q, pay_d;

    // stall on disable or sysref lets the fifo really fill
    assign pop = f_valid && tx_en_in && !sysref_in;

    // eight deep, enough to ride out short drain stalls
    shstr_fifo #(
        .W(`SHSTR_BLK_W),
        .D(`SHSTR_FIFO_DEPTH)
    ) shstr_fifo_inst (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .wr_data_in(blk_in),
        .wr_valid_in(blk_valid_in),
        .wr_ready_out(blk_ready_out),
        .rd_data_out(f_data),
        .rd_valid_out(f_valid),
        .rd_ready_in(pop)
    );

    // E is fixed at one, so every multiblock ends an extended one
    assign word_c = shstr_place(par_q, `SHSTR_EMB_E == 1);
    assign bit_c = word_c[cnt_q];

    // block counter and running parity; a periodic sysref on block 0 changes nothing
    always_comb begin
        cnt_d = cnt_q;
        crc_d = crc_q;
        par_d = par_q;
        if (sysref_in) begin
            cnt_d = 5'h00;
            crc_d = 12'h000;
        end else if (pop) begin
            if (cnt_q == `SHSTR_LAST_BLK) begin
                cnt_d = 5'h00;
                par_d = shstr_crc_step(crc_q, f_data);
                crc_d = 12'h000;
            end else begin
                cnt_d = cnt_q + 5'h01;
                crc_d = shstr_crc_step(crc_q, f_data);
            end
        end
    end

    // previous parity survives a sysref so the next word stays honest
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 5'h00;
            crc_q <= 12'h000;
            par_q <= 12'h000;
        end else begin
            cnt_q <= cnt_d;
            crc_q <= crc_d;
            par_q <= par_d;
        end
    end

    // link stage: header, payload and the multiblock start marker
    always_comb begin
        vld_d = pop;
        sh_d = sh_q;
        pay_d = pay_q;
        first_d = 1'b0;
        if (pop) begin
            sh_d = {~bit_c, bit_c};
            pay_d = f_data;
            first_d = (cnt_q == 5'h00);
        end
    end

    // header resets to a legal 10 and holds its last value while idle, so a stalled link never shows 00 or 11
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vld_q <= 1'b0;
            sh_q <= 2'h2;
            pay_q <= 64'h0000000000000000;
            first_q <= 1'b0;
        end else begin
            vld_q <= vld_d;
            sh_q <= sh_d;
            pay_q <= pay_d;
            first_q <= first_d;
        end
    end

    // link side from registers
    assign link.valid = vld_q;
    assign link.sh = sh_q;
    assign link.payload = pay_q;
    assign lemc_out = first_q;
endmodule

// file: shstr_map.svh
// constants for the sync header stream framing of a 64b/66b link
`ifndef SHSTR_MAP_SVH
`define SHSTR_MAP_SVH

`define SHSTR_BLK_W 64
`define SHSTR_MB_BLOCKS 32
`define SHSTR_LAST_BLK 5'h1F
`define SHSTR_EMB_E 1
`define SHSTR_FIFO_DEPTH 8
// x^12+x^9+x^8+x^3+x^2+x+1 without the x^12 term; 0x987 is the same in implicit-one notation
`define SHSTR_CRC_POLY 12'h30F
// fixed ones, pilot 00001 in bits 27..31, zeros elsewhere
`define SHSTR_PILOT_MASK 32'hF8A88888
`define SHSTR_PILOT_VAL 32'h80A88888
`define SHSTR_EOEMB_BIT 22
`define SHSTR_ERR_LIMIT 3'h4

`endif

// file: shstr_pkg.sv
// types and stream helpers shared by both ends
`include "shstr_map.svh"

package shstr_pkg;

    typedef enum logic [1:0] {
        SHSTR_SEARCH = 2'b00,
        SHSTR_LOCKED = 2'b01,
        SHSTR_WAIT_SYSREF = 2'b10
    } shstr_rx_state_t;

    // serial crc over one block, bit 63 first
    function automatic logic [11:0] shstr_crc_step(input logic [11:0] crc,
                                                   input logic [63:0] data);
        logic [11:0] c;
        logic fb;
        c = crc;
        for (int i = 63; i >= 0; i--) begin
            fb = c[11] ^ data[i];
            c = {c[10:0], 1'b0} ^ (fb ? `SHSTR_CRC_POLY : 12'h000);
        end
        return c;
    endfunction

    // stream word for crc-12 mode; command positions stay zero
    function automatic logic [31:0] shstr_place(input logic [11:0] p, input logic eoemb);
        logic [31:0] w;
        w = `SHSTR_PILOT_VAL;
        {w[0], w[1], w[2]} = p[11:9];
        {w[4], w[5], w[6]} = p[8:6];
        {w[8], w[9], w[10]} = p[5:3];
        {w[12], w[13], w[14]} = p[2:0];
        w[`SHSTR_EOEMB_BIT] = eoemb;
        return w;
    endfunction

    // parity word out of a received stream word
    function automatic logic [11:0] shstr_extract(input logic [31:0] w);
        return {w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[9], w[10], w[12], w[13], w[14]};
    endfunction

endpackage

// file: shstr_if.sv
// block link between the framing transmitter and receiver
`timescale 1ns/1ps

interface shstr_if;
    logic valid;
    logic [1:0] sh;
    logic [63:0] payload;

    modport tx (
        output valid,
        output sh,
        output payload
    );
    modport rx (
        input valid,
        input sh,
        input payload
    );
endinterface

// file: shstr_rx.sv
// sync header stream receiver: alignment, pilot and parity check
`timescale 1ns/1ps
`include "shstr_map.svh"

module shstr_rx
    import shstr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic sysref_in,
    shstr_if.rx link,
    output logic [63:0] blk_out,
    output logic blk_valid_out,
    output logic mb_first_out,
    output logic eoemb_out,
    output logic mb_lock_out,
    output logic hdr_err_out,
    output logic mb_err_out,
    output logic crc_err_out
);
    shstr_rx_state_t st_q, st_d;
    logic b, hdr_bad, pilot_ok, last, mb_bad;
    logic [31:0] word_c, shr_q, shr_d;
    logic [4:0] cnt_q, cnt_d;
    logic [11:0] crc_q, crc_d, par_q, par_d, crc_fin;
    logic prev_q, prev_d;
    logic [2:0] err_q, err_d;
    logic [63:0] dat_q, dat_d;
    logic vld_q, vld_d, first_q, first_d, eo_q, eo_d;
    logic he_q, he_d, me_q, me_d, ce_q, ce_d;

    // second header bit is the stream bit; equal bits are a bad header
    assign b = link.sh[0];
    assign hdr_bad = link.valid && (link.sh[1] == link.sh[0]);
    assign word_c = {b, shr_q[31:1]};
    assign pilot_ok = ((word_c & `SHSTR_PILOT_MASK) == `SHSTR_PILOT_VAL);
    assign last = (cnt_q == `SHSTR_LAST_BLK);
    assign mb_bad = !pilot_ok || !word_c[`SHSTR_EOEMB_BIT];
    assign crc_fin = shstr_crc_step(crc_q, link.payload);

    // alignment state, checks and output staging
    always_comb begin
        st_d = st_q;
        shr_d = shr_q;
        cnt_d = cnt_q;
        crc_d = crc_q;
        par_d = par_q;
        prev_d = prev_q;
        err_d = err_q;
        dat_d = dat_q;
        vld_d = 1'b0;
        first_d = 1'b0;
        eo_d = 1'b0;
        he_d = 1'b0;
        me_d = 1'b0;
        ce_d = 1'b0;
        case (st_q)
            SHSTR_SEARCH: begin
                if (link.valid) begin
                    shr_d = word_c;
                    if (!hdr_bad && pilot_ok) begin
                        st_d = SHSTR_LOCKED;
                        cnt_d = 5'h00;
                        crc_d = 12'h000;
                        prev_d = 1'b0;
                        err_d = 3'h0;
                    end
                end
            end
            SHSTR_LOCKED: begin
                if (link.valid) begin
                    shr_d = word_c;
                    vld_d = 1'b1;
                    dat_d = link.payload;
                    first_d = (cnt_q == 5'h00);
                    he_d = hdr_bad;
                    if (last) begin
                        cnt_d = 5'h00;
                        crc_d = 12'h000;
                        par_d = crc_fin;
                        prev_d = 1'b1;
                        eo_d = word_c[`SHSTR_EOEMB_BIT];
                        me_d = mb_bad;
                        ce_d = prev_q && (shstr_extract(word_c) != par_q);
                    end else begin
                        cnt_d = cnt_q + 5'h01;
                        crc_d = crc_fin;
                    end
                    // repeated errors drop lock; a clean multiblock forgives
                    if (hdr_bad || (last && mb_bad)) begin
                        err_d = err_q + 3'h1;
                        if (err_q + 3'h1 >= `SHSTR_ERR_LIMIT) begin
                            st_d = SHSTR_WAIT_SYSREF;
                        end
                    end else if (last) begin
                        err_d = 3'h0;
                    end
                end
            end
            SHSTR_WAIT_SYSREF: begin
                if (sysref_in) begin
                    st_d = SHSTR_SEARCH;
                    shr_d = 32'h00000000;
                end
            end
            default: begin
                st_d = SHSTR_SEARCH;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= SHSTR_SEARCH;
            shr_q <= 32'h00000000;
            cnt_q <= 5'h00;
            crc_q <= 12'h000;
            par_q <= 12'h000;
            prev_q <= 1'b0;
            err_q <= 3'h0;
            dat_q <= 64'h0000000000000000;
            vld_q <= 1'b0;
            first_q <= 1'b0;
            eo_q <= 1'b0;
            he_q <= 1'b0;
            me_q <= 1'b0;
            ce_q <= 1'b0;
        end else begin
            st_q <= st_d;
            shr_q <= shr_d;
            cnt_q <= cnt_d;
            crc_q <= crc_d;
            par_q <= par_d;
            prev_q <= prev_d;
            err_q <= err_d;
            dat_q <= dat_d;
            vld_q <= vld_d;
            first_q <= first_d;
            eo_q <= eo_d;
            he_q <= he_d;
            me_q <= me_d;
            ce_q <= ce_d;
        end
    end

    assign blk_out = dat_q;
    assign blk_valid_out = vld_q;
    assign mb_first_out = first_q;
    assign eoemb_out = eo_q;
    assign mb_lock_out = (st_q == SHSTR_LOCKED);
    assign hdr_err_out = he_q;
    assign mb_err_out = me_q;
    assign crc_err_out = ce_q;
endmodule

// file: shstr_link_sva.sv
// concurrent checks on the block link between the two ends
`timescale 1ns/1ps

module shstr_link_sva (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic valid_in,
    input wire logic [1:0] sh_in,
    input wire logic [63:0] payload_in
);
    logic [4:0] cnt_q;
    logic [31:0] sw_q;
    logic [11:0] crc_q;
    logic [11:0] par_q;
    logic [31:0] w;
    logic [11:0] px;
    logic e;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // own serial parity, first line bit of a block first
    function automatic logic [11:0] step(input logic [11:0] c, input logic [63:0] d);
        for (int i = 63; i >= 0; i--) begin
            c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? 12'h30F : 12'h000);
        end
        return c;
    endfunction

    // whole stream word as seen with the last block of a multiblock
    assign w = {sh_in == 2'b01, sw_q[30:0]};
    assign px = {w[0], w[1], w[2], w[4], w[5], w[6], w[8], w[9], w[10], w[12], w[13], w[14]};
    assign e = valid_in && (cnt_q == 5'h1F);

    // block count, stream bits and parity of the previous multiblock
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 5'h00;
            sw_q <= 32'h0;
            crc_q <= 12'h000;
            par_q <= 12'h000;
        end else if (valid_in) begin
            cnt_q <= cnt_q + 5'h01;
            sw_q[cnt_q] <= (sh_in == 2'b01);
            crc_q <= e ? 12'h000 : step(crc_q, payload_in);
            par_q <= e ? step(crc_q, payload_in) : par_q;
        end
    end

    AST_SH_PAIR: assert property (valid_in |-> $onehot(sh_in))
        else $error("header bits not complementary");
    AST_EOMB_ZEROS: assert property (e |-> w[30:27] == 4'h0)
        else $error("end pattern zeros wrong");
    AST_EOMB_ONE: assert property (e |-> w[31] == 1'b1)
        else $error("end pattern last bit wrong");
    AST_ONES_LOW: assert property (e |-> {w[3], w[7], w[11], w[15]} == 4'hF)
        else $error("fixed ones in low half wrong");
    AST_ONES_HIGH: assert property (e |-> {w[19], w[21], w[23]} == 3'h7)
        else $error("fixed ones in high half wrong");
    AST_CMD_ZERO: assert property (e |-> {w[26:24], w[20], w[18:16]} == 7'h00)
        else $error("command positions not zero");
    AST_EOEMB: assert property (e |-> w[22] == 1'b1)
        else $error("end flag not set");
    AST_PARITY: assert property (e |-> px == par_q)
        else $error("parity differs from previous multiblock");
endmodule

// file: tb_top.sv
// bench: tx into rx, plus a bench-driven link into a second rx
`timescale 1ns/1ps

module tb_top;
    logic sys_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic sysref_in = 1'b0;
    logic sysref2 = 1'b0;
    logic tx_en_in = 1'b0;
    logic rnd_en = 1'b0;
    logic en_hold = 1'b0;
    logic [63:0] blk_in = 64'h0;
    logic blk_valid_in = 1'b0;
    logic blk_ready_out, lemc_out, took;
    wire [1:0] eo, lk, he, me, ce;
    wire [63:0] bo;
    wire bv, mf;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int fcyc = 0;
    int lcnt = 0;
    int nput = 0;
    int nrx = 0;
    int nacc;
    int n_eo[2];
    int n_he[2];
    int n_me[2];
    int n_ce[2];
    logic [63:0] exp_q[$];
    logic [63:0] rx_q[$];
    shstr_if link1();
    shstr_if link2();

    shstr_tx shstr_tx_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .sysref_in(sysref_in), .tx_en_in(tx_en_in), .blk_in(blk_in),
        .blk_valid_in(blk_valid_in), .blk_ready_out(blk_ready_out), .lemc_out(lemc_out),
        .link(link1.tx));
    shstr_rx shstr_rx_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .sysref_in(sysref_in), .link(link1.rx), .blk_out(bo), .blk_valid_out(bv),
        .mb_first_out(mf), .eoemb_out(eo[0]), .mb_lock_out(lk[0]), .hdr_err_out(he[0]),
        .mb_err_out(me[0]), .crc_err_out(ce[0]));
    shstr_rx shstr_rx_inst_2 (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .sysref_in(sysref2), .link(link2.rx), .blk_out(), .blk_valid_out(),
        .mb_first_out(), .eoemb_out(eo[1]), .mb_lock_out(lk[1]), .hdr_err_out(he[1]),
        .mb_err_out(me[1]), .crc_err_out(ce[1]));
    shstr_link_sva shstr_link_sva_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .valid_in(link1.valid), .sh_in(link1.sh), .payload_in(link1.payload));

    always #10 sys_clk_in = ~sys_clk_in;

    // write acceptance as seen at the edge, so tasks need not race the fifo
    always @(posedge sys_clk_in) took <= blk_valid_in && blk_ready_out;

    // random drain stalls push the fifo to full
    always @(posedge sys_clk_in) begin
        #1;
        tx_en_in = rnd_en ? ($urandom_range(3) != 0) : en_hold;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // wire watch: oldest noted block must be next on the link; pulse counts
    always @(posedge sys_clk_in) begin
        cyc++;
        if (link1.valid) begin
            check(link1.payload, exp_q.size() ? exp_q.pop_front() : ~link1.payload);
            check(64'(lemc_out), 64'(lcnt % 32 == 0));
            lcnt++;
        end
        // receiver output: blocks from the second multiblock on, in order
        if (bv === 1'b1) begin
            check(bo, rx_q.size() ? rx_q.pop_front() : ~bo);
            check(64'(mf), 64'(nrx % 32 == 0));
            check(64'(eo[0]), 64'(nrx % 32 == 31));
            nrx++;
        end
        if (ce[1] === 1'b1) check(64'(cyc - fcyc >= 46), 64'h1);
        for (int i = 0; i < 2; i++) begin
            n_eo[i] += int'(eo[i]);
            n_he[i] += int'(he[i]);
            n_me[i] += int'(me[i]);
            n_ce[i] += int'(ce[i]);
        end
        if (cyc == 5000) begin
            error_cnt++;
            finish_test;
        end
    end

    task automatic put_blk(input logic [63:0] p, output bit ok);
        int n;
        n = 0;
        blk_in = p;
        blk_valid_in = 1'b1;
        do begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end while (took !== 1'b1 && n < 12);
        ok = (took === 1'b1);
        if (ok) begin
            exp_q.push_back(p);
            // the first multiblock is spent on alignment at the receiver
            if (nput >= 32) rx_q.push_back(p);
            nput++;
        end
    endtask

    task automatic blk2(input logic [1:0] s, input logic [63:0] p);
        link2.valid = 1'b1;
        link2.sh = s;
        link2.payload = p;
        @(posedge sys_clk_in);
        #1;
    endtask

    // one multiblock of zero payload, optional flipped first bit at block flip
    task automatic mb2(input logic eo_bit, input int flip);
        logic [31:0] w;
        w = 32'h80A88888;
        w[22] = eo_bit;
        for (int k = 0; k < 32; k++) begin
            if (k == flip) fcyc = cyc;
            blk2(w[k] ? 2'b01 : 2'b10, (k == flip) ? 64'h8000000000000000 : 64'h0);
        end
    endtask

    task automatic idle2;
        link2.valid = 1'b0;
        link2.payload = ~link2.payload;
        repeat (2) @(posedge sys_clk_in);
        #1;
    endtask

    initial begin
        bit ok;
        void'($urandom(32'h8FEBF535));
        link2.valid = 1'b0;
        link2.sh = 2'b10;
        link2.payload = 64'h0;
        repeat (10) @(posedge sys_clk_in);
        #1;
        arst_n_in = 1'b1;
        sysref_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        sysref_in = 1'b0;
        // fill with drain stopped: the ninth write is refused
        nacc = 0;
        repeat (9) begin
            put_blk({$urandom, $urandom}, ok);
            nacc += ok;
        end
        blk_valid_in = 1'b0;
        check(64'(nacc), 64'h8);
        rnd_en = 1'b1;
        repeat (120) put_blk({$urandom, $urandom}, ok);
        blk_valid_in = 1'b0;
        rnd_en = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        en_hold = 1'b1;
        for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge sys_clk_in);
        repeat (3) @(posedge sys_clk_in);
        #1;
        check(64'(exp_q.size()), 64'h0);
        check(64'(rx_q.size()), 64'h0);
        check(64'(lk[0]), 64'h1);
        check(64'(n_ce[0]), 64'h0);
        check(64'(n_me[0] + n_he[0]), 64'h0);
        check(64'(n_eo[0] > 0), 64'h1);
        // second link: lock, parity fault, header faults, relock, bad end flag
        repeat (2) mb2(1'b1, -1);
        check(64'(lk[1]), 64'h1);
        mb2(1'b1, 0);
        mb2(1'b1, -1);
        for (int k = 0; k < 4; k++) blk2({k[0], k[0]}, 64'h0);
        idle2();
        check(64'(n_ce[1]), 64'h1);
        check(64'(n_he[1]), 64'h4);
        check(64'(lk[1]), 64'h0);
        sysref2 = 1'b1;
        @(posedge sys_clk_in);
        #1;
        sysref2 = 1'b0;
        mb2(1'b1, -1);
        idle2();
        check(64'(lk[1]), 64'h1);
        mb2(1'b0, -1);
        idle2();
        check(64'(n_me[1]), 64'h1);
        finish_test;
    end
endmodule
